/* File: pkg/gpr_pkg.sv */
// Shared constants and types for the register file and sequencer
// Functional notes
// - Thirty-two general registers of 32 bits each
// - Register zero reads zero, ignores writes
// - Two read ports plus one result bus port
// - Store data driven on result bus
// - One in-use bit per register except zero
// - Multicycle instructions mark all destinations busy
// - Issue stalls while sources or destinations busy
// - Availability re-checked every cycle while stalled
// - Writes via result bus, reads via sources
// - Result forwarded to source bus same cycle
// - Both operands may arrive by forwarding
// - Operands received then destinations marked, execute
// - Pending exception: only memory results granted
// - Grant gates result into arbiter-chosen register
// - Priority: single-cycle, then float, then data
// - Grant also steers forwarding onto source bus
// - Exceptions: precise, interrupt, then imprecise
// - Flow control flushes pipe, loads branch target
// - Buses 32 bits; sixteen-bit immediate source
// - Instruction unit picks sources, sequencer gates
package gpr_pkg;

  localparam int unsigned NUM_REGS  = 32;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned IDX_W     = 5;
  localparam int unsigned IMM_W     = 16;
  localparam int unsigned NUM_UNITS = 3;

  // Writeback requester slots, lowest index wins
  localparam int unsigned U_SINGLE = 0;
  localparam int unsigned U_FPU    = 1;
  localparam int unsigned U_DATA   = 2;

  localparam logic [IDX_W-1:0]    ZERO_IDX   = 5'h00;
  localparam logic [NUM_REGS-1:0] SB_RESET   = 32'h0000_0000;
  localparam logic [DATA_W-1:0]   DATA_RESET = 32'h0000_0000;

  // Recognised exception, one-hot
  typedef enum logic [3:0] {
    EXC_NONE      = 4'h1,
    EXC_PRECISE   = 4'h2,
    EXC_INTERRUPT = 4'h4,
    EXC_IMPRECISE = 4'h8
  } exc_kind_e;

endpackage

/* File: pkg/wb_arb_if.sv */
// Writeback arbitration signals between the sequencer core and its arbiter
`timescale 1ns/1ns
interface wb_arb_if;
  logic [gpr_pkg::NUM_UNITS-1:0] req;
  logic [gpr_pkg::IDX_W-1:0]     dest [gpr_pkg::NUM_UNITS];
  logic                          exc_pending;
  logic [gpr_pkg::NUM_UNITS-1:0] gnt;
  logic                          wr_en;
  logic [gpr_pkg::IDX_W-1:0]     wr_idx;

  modport arb  (input req, dest, exc_pending, output gnt, wr_en, wr_idx);
  modport core (output req, dest, exc_pending, input gnt, wr_en, wr_idx);
endinterface

/* File: hw/wb_arbiter.sv */
// Fixed-priority writeback arbiter with exception gating
`timescale 1ns/1ns
module wb_arbiter (
  wb_arb_if.arb wb
);

  logic [gpr_pkg::NUM_UNITS-1:0] elig;

  // Only memory results may write back during an exception
  always_comb
  begin
    elig = wb.req;
    if (wb.exc_pending)
    begin
      elig = wb.req & (3'h1 << gpr_pkg::U_DATA);
    end
  end

  // Lowest slot index wins; one grant per cycle since one result bus
  always_comb
  begin
    wb.gnt    = '0;
    wb.wr_en  = 1'b0;
    wb.wr_idx = gpr_pkg::ZERO_IDX;
    for (int i = gpr_pkg::NUM_UNITS - 1; i >= 0; i--)
    begin
      if (elig[i])
      begin
        wb.gnt    = 3'h1 << i;
        wb.wr_en  = 1'b1;
        wb.wr_idx = wb.dest[i];
      end
    end
  end

endmodule

/* File: hw/exc_arbiter.sv */
// Exception recognition by fixed priority
`timescale 1ns/1ns
module exc_arbiter (
  // Competing exception requests
  input  wire logic        precise_i,
  input  wire logic        interrupt_i,
  input  wire logic        imprecise_i,
  // Chosen exception
  output gpr_pkg::exc_kind_e kind_o
);

  // Precise beats interrupt beats imprecise
  always_comb
  begin
    if (precise_i)
      kind_o = gpr_pkg::EXC_PRECISE;
    else if (interrupt_i)
      kind_o = gpr_pkg::EXC_INTERRUPT;
    else if (imprecise_i)
      kind_o = gpr_pkg::EXC_IMPRECISE;
    else
      kind_o = gpr_pkg::EXC_NONE;
  end

endmodule

/* File: hw/gpr_file_scoreboard_sequencer.sv */
// Register file, scoreboard, forwarding and sequencer top
`timescale 1ns/1ns
module gpr_file_scoreboard_sequencer (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Issue request from the instruction unit
  input  wire logic        iss_valid_i,
  input  wire logic [4:0]  iss_src1_idx_i,
  input  wire logic [4:0]  iss_src2_idx_i,
  input  wire logic        iss_src2_imm_i,
  input  wire logic [15:0] iss_imm_i,
  input  wire logic [4:0]  iss_dest_idx_i,
  input  wire logic        iss_dest_pair_i,
  input  wire logic        iss_has_dest_i,
  input  wire logic        iss_multi_i,
  input  wire logic        iss_store_i,
  input  wire logic [4:0]  iss_store_idx_i,
  output logic             iss_stall_o,
  output logic             iss_accept_o,
  // Source buses
  output logic [31:0]      source_bus_one_o,
  output logic [31:0]      source_bus_two_o,
  output logic             source_valid_o,
  output logic [1:0]       fwd_hit_o,
  // Writeback requests: single-cycle, float, data unit
  input  wire logic [2:0]  wb_req_i,
  input  wire logic [4:0]  wb_dest_single_i,
  input  wire logic [4:0]  wb_dest_fpu_i,
  input  wire logic [4:0]  wb_dest_data_i,
  input  wire logic [31:0] wb_data_single_i,
  input  wire logic [31:0] wb_data_fpu_i,
  input  wire logic [31:0] wb_data_data_i,
  output logic [2:0]       wb_gnt_o,
  // Result bus, two-way: oe high while the file drives store data
  input  wire logic [31:0] result_bus_i,
  output logic [31:0]      result_bus_o,
  output logic             result_bus_oe_o,
  // Exceptions
  input  wire logic        exc_precise_i,
  input  wire logic        exc_interrupt_i,
  input  wire logic        exc_imprecise_i,
  input  wire logic        exc_done_i,
  output logic             exc_pending_o,
  output logic [3:0]       exc_kind_o,
  // Branch unit and prefetcher control
  input  wire logic        br_taken_i,
  input  wire logic [31:0] br_target_i,
  output logic             pipe_flush_o,
  output logic             target_load_o,
  output logic [31:0]      target_addr_o,
  output logic             fetch_hold_o
);

  localparam int unsigned DW = gpr_pkg::DATA_W;
  localparam int unsigned NR = gpr_pkg::NUM_REGS;

  // Register array; entry zero is never written
  logic [DW-1:0] gpr_mem [NR];

  logic [NR-1:0]      sb_reg;
  logic [NR-1:0]      sb_next;
  logic [DW-1:0]      src1_reg;
  logic [DW-1:0]      src1_next;
  logic [DW-1:0]      src2_reg;
  logic [DW-1:0]      src2_next;
  logic               srcv_reg;
  logic               srcv_next;
  logic [1:0]         fwd_reg;
  logic [1:0]         fwd_next;
  logic [DW-1:0]      rbus_reg;
  logic [DW-1:0]      rbus_next;
  logic               rbus_oe_reg;
  logic               rbus_oe_next;
  logic               exc_pend_reg;
  logic               exc_pend_next;
  logic [3:0]         exc_kind_reg;
  logic [3:0]         exc_kind_next;
  logic               flush_reg;
  logic               flush_next;
  logic               tload_reg;
  logic               tload_next;
  logic [DW-1:0]      taddr_reg;
  logic [DW-1:0]      taddr_next;

  gpr_pkg::exc_kind_e exc_win;
  logic [DW-1:0]      wr_data;
  logic [NR-1:0]      wr_mask;
  logic [NR-1:0]      busy_eff;
  logic [NR-1:0]      need_mask;
  logic [NR-1:0]      dest_mask;
  logic               stall;
  logic               accept;
  logic               fwd1;
  logic               fwd2;
  logic [DW-1:0]      rd1;
  logic [DW-1:0]      rd2;
  logic [DW-1:0]      rd_store;

  wb_arb_if wb ();

  // Writeback arbitration lives in its own module
  assign wb.req         = wb_req_i;
  assign wb.dest[0]     = wb_dest_single_i;
  assign wb.dest[1]     = wb_dest_fpu_i;
  assign wb.dest[2]     = wb_dest_data_i;
  assign wb.exc_pending = exc_pend_reg;
  assign wb_gnt_o       = wb.gnt;

  wb_arbiter u_wb_arbiter (
    .wb (wb)
  );

  exc_arbiter u_exc_arbiter (
    .precise_i   (exc_precise_i),
    .interrupt_i (exc_interrupt_i),
    .imprecise_i (exc_imprecise_i),
    .kind_o      (exc_win)
  );

  // Granted unit's data is the result bus value this cycle
  always_comb
  begin
    case (wb.gnt)
      3'h1:    wr_data = wb_data_single_i;
      3'h2:    wr_data = wb_data_fpu_i;
      3'h4:    wr_data = wb_data_data_i;
      default: wr_data = result_bus_i;
    endcase
    wr_mask = '0;
    if (wb.wr_en && wb.wr_idx != gpr_pkg::ZERO_IDX)
      wr_mask = 32'h1 << wb.wr_idx;
  end

  // Busy bits that are being released by this cycle's write still allow
  // issue, since the operand is forwarded in the same cycle
  always_comb
  begin
    busy_eff  = sb_reg & ~wr_mask;
    need_mask = 32'h1 << iss_src1_idx_i;
    if (!iss_src2_imm_i)
      need_mask = need_mask | (32'h1 << iss_src2_idx_i);
    if (iss_store_i)
      need_mask = need_mask | (32'h1 << iss_store_idx_i);
    dest_mask = '0;
    if (iss_has_dest_i)
    begin
      dest_mask = 32'h1 << iss_dest_idx_i;
      if (iss_dest_pair_i)
        dest_mask = dest_mask | (32'h1 << 5'(iss_dest_idx_i + 5'h01));
    end
    need_mask = (need_mask | dest_mask) & ~32'h1;
    dest_mask = dest_mask & ~32'h1;
    // Store data shares the result bus, so it waits out a writeback
    stall = iss_valid_i && (((busy_eff & need_mask) != '0) ||
            (iss_store_i && wb.wr_en));
    accept = iss_valid_i && !stall;
    fwd1 = wb.wr_en && wb.wr_idx == iss_src1_idx_i &&
           iss_src1_idx_i != gpr_pkg::ZERO_IDX;
    fwd2 = wb.wr_en && wb.wr_idx == iss_src2_idx_i &&
           iss_src2_idx_i != gpr_pkg::ZERO_IDX && !iss_src2_imm_i;
  end

  assign iss_stall_o  = stall;
  assign iss_accept_o = accept;

  // Scoreboard: a new destination mark wins over a write-back release
  always_comb
  begin
    sb_next = sb_reg & ~wr_mask;
    if (accept && iss_multi_i)
      sb_next = sb_next | dest_mask;
    sb_next[0] = 1'b0;
  end

  // Array reads; entry zero is never stored, so the mux supplies the constant
  always_comb
  begin
    rd1      = gpr_mem[iss_src1_idx_i];
    rd2      = gpr_mem[iss_src2_idx_i];
    rd_store = gpr_mem[iss_store_idx_i];
    if (iss_src1_idx_i == gpr_pkg::ZERO_IDX)
      rd1 = gpr_pkg::DATA_RESET;
    if (iss_src2_idx_i == gpr_pkg::ZERO_IDX)
      rd2 = gpr_pkg::DATA_RESET;
    if (iss_store_idx_i == gpr_pkg::ZERO_IDX)
      rd_store = gpr_pkg::DATA_RESET;
  end

  // Source buses, loaded when the instruction is accepted
  always_comb
  begin
    src1_next = src1_reg;
    src2_next = src2_reg;
    fwd_next  = 2'h0;
    srcv_next = accept;
    if (accept)
    begin
      src1_next = fwd1 ? wr_data : rd1;
      if (iss_src2_imm_i)
        src2_next = {16'h0000, iss_imm_i};
      else
        src2_next = fwd2 ? wr_data : rd2;
      fwd_next = {fwd2, fwd1};
    end
  end

  // Result bus mirror: store data driven out, else last written result
  always_comb
  begin
    rbus_next    = rbus_reg;
    rbus_oe_next = 1'b0;
    if (accept && iss_store_i)
    begin
      rbus_next    = rd_store;
      rbus_oe_next = 1'b1;
    end
    else if (wb.wr_en)
      rbus_next = wr_data;
  end

  // Exception arbitration and flow control toward the prefetcher
  always_comb
  begin
    exc_pend_next = exc_pend_reg;
    exc_kind_next = exc_kind_reg;
    if (exc_win != gpr_pkg::EXC_NONE && !exc_pend_reg)
    begin
      exc_pend_next = 1'b1;
      exc_kind_next = exc_win;
    end
    else if (exc_done_i)
    begin
      exc_pend_next = 1'b0;
      exc_kind_next = gpr_pkg::EXC_NONE;
    end
    // Exception flush overrides a branch load the same cycle
    flush_next = (exc_win != gpr_pkg::EXC_NONE && !exc_pend_reg) ||
                 br_taken_i;
    tload_next = br_taken_i && exc_win == gpr_pkg::EXC_NONE && !exc_pend_reg;
    taddr_next = tload_next ? br_target_i : taddr_reg;
  end

  assign fetch_hold_o = stall;

  // Register array write; entry zero stays constant
  always_ff @(posedge sys_clk_i)
  begin
    for (int i = 1; i < NR; i++)
    begin
      if (wr_mask[i])
        gpr_mem[i] <= wr_data;
    end
  end

  // State registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sb_reg       <= gpr_pkg::SB_RESET;
      src1_reg     <= gpr_pkg::DATA_RESET;
      src2_reg     <= gpr_pkg::DATA_RESET;
      srcv_reg     <= 1'b0;
      fwd_reg      <= 2'h0;
      rbus_reg     <= gpr_pkg::DATA_RESET;
      rbus_oe_reg  <= 1'b0;
      exc_pend_reg <= 1'b0;
      exc_kind_reg <= gpr_pkg::EXC_NONE;
      flush_reg    <= 1'b0;
      tload_reg    <= 1'b0;
      taddr_reg    <= gpr_pkg::DATA_RESET;
    end
    else
    begin
      sb_reg       <= sb_next;
      src1_reg     <= src1_next;
      src2_reg     <= src2_next;
      srcv_reg     <= srcv_next;
      fwd_reg      <= fwd_next;
      rbus_reg     <= rbus_next;
      rbus_oe_reg  <= rbus_oe_next;
      exc_pend_reg <= exc_pend_next;
      exc_kind_reg <= exc_kind_next;
      flush_reg    <= flush_next;
      tload_reg    <= tload_next;
      taddr_reg    <= taddr_next;
    end
  end

  // Outputs straight from flip-flops
  assign source_bus_one_o = src1_reg;
  assign source_bus_two_o = src2_reg;
  assign source_valid_o   = srcv_reg;
  assign fwd_hit_o        = fwd_reg;
  assign result_bus_o     = rbus_reg;
  assign result_bus_oe_o  = rbus_oe_reg;
  assign exc_pending_o    = exc_pend_reg;
  assign exc_kind_o       = exc_kind_reg;
  assign pipe_flush_o     = flush_reg;
  assign target_load_o    = tload_reg;
  assign target_addr_o    = taddr_reg;

endmodule

/* File: verif/gpr_seq_assertions.sv */
// Port-level checks for the register file sequencer
`timescale 1ns/1ns
module gpr_seq_assertions (
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  // Issue side
  input wire logic        iss_valid_i,
  input wire logic        iss_src2_imm_i,
  input wire logic [15:0] iss_imm_i,
  input wire logic        iss_store_i,
  input wire logic        iss_stall_o,
  input wire logic        iss_accept_o,
  input wire logic [31:0] source_bus_two_o,
  input wire logic        source_valid_o,
  // Writeback and exceptions
  input wire logic [2:0]  wb_req_i,
  input wire logic [2:0]  wb_gnt_o,
  input wire logic        result_bus_oe_o,
  input wire logic        exc_precise_i,
  input wire logic        exc_pending_o,
  input wire logic [3:0]  exc_kind_o,
  input wire logic        pipe_flush_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Issue handshake and operand delivery
  a_accept_then_valid: assert property (iss_accept_o |=> source_valid_o)
    else $error("operands missing after accept");
  a_stall_holds_issue: assert property (iss_valid_i && iss_stall_o |-> !iss_accept_o ##1 !source_valid_o)
    else $error("issue went ahead while stalled");
  a_imm_zero_ext: assert property (iss_accept_o && iss_src2_imm_i |=> source_bus_two_o == {16'h0000, $past(iss_imm_i)})
    else $error("immediate operand wrong");
  a_store_drives_bus: assert property (iss_accept_o && iss_store_i |=> result_bus_oe_o)
    else $error("store data not driven");
  // Writeback priority; exceptions only let memory results through
  a_gnt_single_first: assert property (wb_req_i[0] && !exc_pending_o |-> wb_gnt_o == 3'h1)
    else $error("single-cycle result not first");
  a_gnt_float_next: assert property (wb_req_i == 3'h6 && !exc_pending_o |-> wb_gnt_o == 3'h2)
    else $error("float result not before data unit");
  a_exc_data_only: assert property (exc_pending_o |-> wb_gnt_o == (wb_req_i & 3'h4))
    else $error("grant given while exception pending");
  a_precise_wins: assert property (!exc_pending_o && exc_precise_i |=> exc_pending_o && exc_kind_o == 4'h2)
    else $error("precise exception not recognised first");
  a_exc_flushes: assert property ($rose(exc_pending_o) |-> pipe_flush_o)
    else $error("no pipeline flush on exception");

  // Main scenarios reached
  c_stall: cover property (iss_valid_i && iss_stall_o);
  c_all_req: cover property (wb_req_i == 3'h7);
  c_exc_data: cover property (exc_pending_o && wb_gnt_o == 3'h4);
endmodule

bind gpr_file_scoreboard_sequencer gpr_seq_assertions i_gpr_seq_assertions (.*);

/* File: verif/exec_unit_model.sv */
// Behavioural execution unit holding one result until granted
`timescale 1ns/1ns
module exec_unit_model (
  // Clock and command from the bench
  input  wire logic        clk_i,
  input  wire logic        start_i,
  input  wire logic [4:0]  dest_i,
  input  wire logic [31:0] data_i,
  // Writeback handshake
  input  wire logic        gnt_i,
  output logic             req_o = 1'b0,
  output logic [4:0]       dest_o = 5'h00,
  output logic [31:0]      data_o = 32'h0000_0000
);
  logic taken = 1'b0;

  // Grant seen at the edge that writes the register
  always @(posedge clk_i)
    taken <= req_o && gnt_i;

  // Request held until granted; payload scrambled after release
  always @(negedge clk_i)
  begin
    if (start_i)
    begin
      req_o <= 1'b1;
      dest_o <= dest_i;
      data_o <= data_i;
    end
    else if (taken)
    begin
      req_o <= 1'b0;
      dest_o <= ~dest_o;
      data_o <= ~data_o;
    end
  end
endmodule

/* File: verif/gpr_file_scoreboard_sequencer_bench.sv */
// Self-checking bench for the register file sequencer
`timescale 1ns/1ns
module gpr_file_scoreboard_sequencer_bench;
  logic        sys_clk_i, rst_n_i, iss_valid_i, iss_src2_imm_i, iss_dest_pair_i;
  logic        iss_has_dest_i, iss_multi_i, iss_store_i, iss_stall_o, iss_accept_o;
  logic        source_valid_o, result_bus_oe_o, exc_precise_i, exc_interrupt_i;
  logic        exc_imprecise_i, exc_done_i, exc_pending_o, br_taken_i, pipe_flush_o;
  logic        target_load_o, fetch_hold_o;
  logic [1:0]  fwd_hit_o;
  logic [2:0]  wb_req_i, wb_gnt_o, start;
  logic [3:0]  exc_kind_o;
  logic [4:0]  iss_src1_idx_i, iss_src2_idx_i, iss_dest_idx_i, iss_store_idx_i, cmd_dest;
  logic [4:0]  wb_dest_single_i, wb_dest_fpu_i, wb_dest_data_i;
  logic [4:0]  dst [3];
  logic [15:0] iss_imm_i;
  logic [31:0] source_bus_one_o, source_bus_two_o, wb_data_single_i, wb_data_fpu_i;
  logic [31:0] wb_data_data_i, result_bus_i, result_bus_o, br_target_i, target_addr_o;
  logic [31:0] cmd_data;
  logic [31:0] dat [3];
  int          bad_count, n_checks;
  // Rows: register, value written, value read back
  logic [68:0] rows [4] = '{{5'h03, 32'hA5A5_0001, 32'hA5A5_0001},
                            {5'h1F, 32'h0123_4567, 32'h0123_4567},
                            {5'h00, 32'hFFFF_FFFF, 32'h0000_0000},
                            {5'h01, 32'h8000_0000, 32'h8000_0000}};
  // Rows: precise, interrupt, imprecise, recognised kind
  logic [6:0]  erows [3] = '{7'b111_0010, 7'b011_0100, 7'b001_1000};

  gpr_file_scoreboard_sequencer i_gpr_file_scoreboard_sequencer (.*);

  // Three execution units, one per writeback slot
  for (genvar g = 0; g < 3; g++)
  begin : g_unit
    exec_unit_model i_exec_unit_model (.clk_i(sys_clk_i), .start_i(start[g]),
      .dest_i(cmd_dest + 5'(g)), .data_i(cmd_data + 32'(g)), .gnt_i(wb_gnt_o[g]),
      .req_o(wb_req_i[g]), .dest_o(dst[g]), .data_o(dat[g]));
  end
  assign {wb_dest_single_i, wb_dest_fpu_i, wb_dest_data_i} = {dst[0], dst[1], dst[2]};
  assign {wb_data_single_i, wb_data_fpu_i, wb_data_data_i} = {dat[0], dat[1], dat[2]};
  // Only the file drives the bus level it reads back
  assign result_bus_i = result_bus_o;

  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic hang;
    bad_count++;
    finish_test();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  // Launch results; unit g gets destination d+g and value v+g
  task automatic wb(input logic [2:0] m, input logic [4:0] d, input logic [31:0] v);
    @(negedge sys_clk_i);
    start <= m;
    cmd_dest <= d;
    cmd_data <= v;
    @(negedge sys_clk_i);
    start <= 3'h0;
  endtask

  task automatic idle;
    int n;
    for (n = 0; n < 40 && wb_req_i !== 3'h0; n++)
      @(negedge sys_clk_i);
    if (n == 40)
      hang();
  endtask

  // Flags f: store, multicycle, has destination
  task automatic issue(input logic [4:0] s1, input logic [4:0] d, input logic [2:0] f);
    int n;
    @(negedge sys_clk_i);
    iss_valid_i <= 1'b1;
    iss_src1_idx_i <= s1;
    iss_store_idx_i <= s1;
    iss_dest_idx_i <= d;
    {iss_store_i, iss_multi_i, iss_has_dest_i} <= f;
    for (n = 0; n < 40 && iss_accept_o !== 1'b1; n++)
      @(posedge sys_clk_i);
    if (n == 40)
      hang();
    @(negedge sys_clk_i);
    iss_valid_i <= 1'b0;
    chk(source_valid_o, 1'b1);
  endtask

  initial
  begin
    #200000;
    hang();
  end

  initial
  begin
    {rst_n_i, iss_valid_i, iss_dest_pair_i, iss_has_dest_i, iss_multi_i, iss_store_i} = 6'h00;
    {exc_precise_i, exc_interrupt_i, exc_imprecise_i, exc_done_i, br_taken_i} = 5'h00;
    {iss_src1_idx_i, iss_src2_idx_i, iss_dest_idx_i, iss_store_idx_i, cmd_dest} = 25'h0;
    {iss_src2_imm_i, iss_imm_i, start, br_target_i, cmd_data} = 84'h0;
    iss_src2_imm_i = 1'b1;
    iss_imm_i = 16'h8001;
    bad_count = 0;
    n_checks = 0;
    repeat (8) @(negedge sys_clk_i);
    chk(exc_kind_o, 4'h1);
    chk(exc_pending_o, 1'b0);
    rst_n_i <= 1'b1;
    // Write each listed register through the result bus, read it back
    for (int r = 0; r < 4; r++)
    begin
      wb(3'h1, rows[r][68:64], rows[r][63:32]);
      idle();
      issue(rows[r][68:64], 5'h00, 3'h0);
      chk(source_bus_one_o, rows[r][31:0]);
      chk(source_bus_two_o, 32'h0000_8001);
    end
    // All three units at once: one grant a cycle by priority
    wb(3'h7, 5'h08, 32'h1000_0000);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge sys_clk_i);
      chk(wb_gnt_o, 32'h1 << k);
    end
    idle();
    // Store data of the float result goes out on the result bus
    issue(5'h09, 5'h00, 3'b100);
    chk(result_bus_oe_o, 1'b1);
    chk(result_bus_o, 32'h1000_0001);
    // Busy destination pair stalls a reader of both operands until forwarded
    iss_dest_pair_i <= 1'b1;
    issue(5'h00, 5'h05, 3'b011);
    {iss_dest_pair_i, iss_src2_imm_i, iss_src2_idx_i} <= {1'b0, 1'b0, 5'h05};
    fork
      issue(5'h05, 5'h00, 3'h0);
      begin
        repeat (3) @(negedge sys_clk_i);
        chk(iss_stall_o, 1'b1);
        chk(fetch_hold_o, 1'b1);
        wb(3'h2, 5'h04, 32'hCAFE_0000);
      end
    join
    chk(source_bus_one_o, 32'hCAFE_0001);
    chk(source_bus_two_o, 32'hCAFE_0001);
    chk(fwd_hit_o, 2'h3);
    // Second half of the pair stays busy until its own result arrives
    iss_src2_imm_i <= 1'b1;
    fork
      issue(5'h06, 5'h00, 3'h0);
      begin
        repeat (2) @(negedge sys_clk_i);
        chk(iss_stall_o, 1'b1);
        wb(3'h1, 5'h06, 32'h0000_6000);
      end
    join
    chk(source_bus_one_o, 32'h0000_6000);
    // Each exception mix, with writeback held back while pending
    for (int e = 0; e < 3; e++)
    begin
      @(negedge sys_clk_i);
      {exc_precise_i, exc_interrupt_i, exc_imprecise_i} <= erows[e][6:4];
      @(negedge sys_clk_i);
      {exc_precise_i, exc_interrupt_i, exc_imprecise_i} <= 3'h0;
      chk(exc_kind_o, erows[e][3:0]);
      chk(pipe_flush_o, 1'b1);
      wb(3'h6, 5'h0B, 32'h2000_0000);
      @(posedge sys_clk_i);
      chk(wb_gnt_o, 3'h4);
      @(posedge sys_clk_i);
      chk(wb_gnt_o, 3'h0);
      @(negedge sys_clk_i);
      exc_done_i <= 1'b1;
      @(negedge sys_clk_i);
      exc_done_i <= 1'b0;
      idle();
      chk(exc_pending_o, 1'b0);
    end
    // Taken branch loads the target address
    @(negedge sys_clk_i);
    br_taken_i <= 1'b1;
    br_target_i <= 32'h0000_4000;
    @(negedge sys_clk_i);
    br_taken_i <= 1'b0;
    chk(target_load_o, 1'b1);
    chk(target_addr_o, 32'h0000_4000);
    finish_test();
  end
endmodule
